// >>> design/dcpt_timer.sv
// Purpose: two-channel capture/compare/pwm timer with 16-bit counter
// Assumes: single core clock, byte register port, pins are two-way
// Notes: pin and external clock inputs pass two flip-flops first
`timescale 1ns/100ps
module dcpt_timer
	import dcpt_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              external_timer_clock_pin,
	input  wire logic              channel_zero_pin_level,
	output logic                   channel_zero_pin_drive,
	output logic                   channel_zero_pin_oe,
	input  wire logic              channel_one_pin_level,
	output logic                   channel_one_pin_drive,
	output logic                   channel_one_pin_oe,
	output logic                   irq_req
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic [CNT_W-1:0]  mod_r;
	logic [PRE_W-1:0]  pre_cnt_r;
	logic [PRE_W-1:0]  pre_mask;
	logic [PS_W-1:0]   ps_r;
	logic              stop_r;
	logic              ovf_ie_r;
	logic              ovf_flag_r;
	logic              cnt_clear;
	logic              tick_int;
	logic              step;
	logic              wrap;
	logic              ext_s1_r;
	logic              ext_s2_r;
	logic              ext_d_r;
	logic              ext_rise;
	logic [7:0]        lo_latch_r;
	logic              lo_hold_r;
	logic              link;
	logic              act_sel_r;
	logic              pend_sel_r;
	logic              pend_sel_nxt;
	logic              wr_val0;
	logic              wr_val1;
	logic [DATA_W-1:0] rd_nxt;

	dcpt_ch_cfg_t      ch_cfg_r  [NCH];
	dcpt_ch_cfg_t      ch_cfg_eff[NCH];
	logic [CNT_W-1:0]  ch_val_r  [NCH];
	logic [CNT_W-1:0]  ch_cmp    [NCH];
	logic              ch_flag_r [NCH];
	logic              ch_s1_r   [NCH];
	logic              ch_s2_r   [NCH];
	logic              cap_evt   [NCH];
	logic              cmp_evt   [NCH];
	logic              ch_pin    [NCH];
	logic              ch_drive  [NCH];
	logic              ch_wr_sc  [NCH];
	logic              ch_wr_hi  [NCH];
	logic              ch_wr_lo  [NCH];

	////////////////////////////////////////////////////////////////////////
	// prescaler and counter clock select

	// free prescaler; reset bit clears it together with the counter
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			pre_cnt_r <= '0;
		else if (cnt_clear)
			pre_cnt_r <= '0;
		else
			pre_cnt_r <= PRE_W'(pre_cnt_r + 1'b1);
	end

	// external clock pin: two-stage synchroniser, then edge register
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_d_r  <= 1'b0;
		end
		else
		begin
			ext_s1_r <= external_timer_clock_pin;
			ext_s2_r <= ext_s1_r;
			ext_d_r  <= ext_s2_r;
		end
	end

	// tap k fires once every 2^k core cycles
	assign pre_mask = PRE_W'((7'h01 << ps_r) - 7'h01);
	assign tick_int = &(pre_cnt_r | ~pre_mask);
	assign ext_rise = ext_s2_r & ~ext_d_r;
	assign step     = ~stop_r & ((ps_r == PS_EXT) ? ext_rise : tick_int);

	////////////////////////////////////////////////////////////////////////
	// counter

	// wrap after the modulo value: period is modulo plus one ticks
	assign wrap    = step & (cnt_r == mod_r);
	assign cnt_nxt = wrap ? CNT_ZERO : CNT_W'(cnt_r + 1'b1);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_r <= CNT_ZERO;
		else if (cnt_clear)
			cnt_r <= CNT_ZERO;
		else if (step)
			cnt_r <= cnt_nxt;
	end

	// reading the high byte freezes the low byte for a coherent pair
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lo_latch_r <= '0;
			lo_hold_r  <= 1'b0;
		end
		else if (reg_rd && reg_addr == ADR_CNT_HI)
		begin
			lo_latch_r <= cnt_r[7:0];
			lo_hold_r  <= 1'b1;
		end
		else if (reg_rd && reg_addr == ADR_CNT_LO)
			lo_hold_r  <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// timer status/control and modulo registers

	assign cnt_clear = reg_wr & (reg_addr == ADR_STATUS) & reg_wdata[SC_RST];

	// prescaler select, stop and overflow enable
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ps_r     <= PS_RST;
			stop_r   <= STOP_RST;
			ovf_ie_r <= 1'b0;
		end
		else if (reg_wr && reg_addr == ADR_STATUS)
		begin
			ps_r     <= reg_wdata[PS_W-1:0];
			stop_r   <= reg_wdata[SC_STOP];
			ovf_ie_r <= reg_wdata[SC_IRQEN];
		end
	end

	// overflow flag: set at wrap, cleared by writing zero, set wins
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ovf_flag_r <= 1'b0;
		else if (wrap)
			ovf_flag_r <= 1'b1;
		else if (reg_wr && reg_addr == ADR_STATUS && !reg_wdata[SC_FLAG])
			ovf_flag_r <= 1'b0;
	end

	// modulo bytes
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			mod_r <= MOD_RST;
		else if (reg_wr && reg_addr == ADR_MOD_HI)
			mod_r[15:8] <= reg_wdata;
		else if (reg_wr && reg_addr == ADR_MOD_LO)
			mod_r[7:0]  <= reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// buffered pairing of channels 0 and 1

	assign link         = ch_cfg_r[0].mode[1];
	assign wr_val0      = ch_wr_hi[0] | ch_wr_lo[0];
	assign wr_val1      = ch_wr_hi[1] | ch_wr_lo[1];
	assign pend_sel_nxt = wr_val1 ? 1'b1 : (wr_val0 ? 1'b0 : pend_sel_r);

	// the set written last takes over at the next overflow
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			act_sel_r  <= 1'b0;
			pend_sel_r <= 1'b0;
		end
		else if (!link)
		begin
			act_sel_r  <= 1'b0;
			pend_sel_r <= 1'b0;
		end
		else
		begin
			pend_sel_r <= pend_sel_nxt;
			if (wrap)
				act_sel_r <= pend_sel_nxt;
		end
	end

	// linked: channel 0 compares against the active set, channel 1 idles
	assign ch_cmp[0]     = (link && act_sel_r) ? ch_val_r[1] : ch_val_r[0];
	assign ch_cmp[1]     = ch_val_r[1];
	assign ch_cfg_eff[0] = ch_cfg_r[0];
	assign ch_cfg_eff[1] = link ? CH_CFG_RST : ch_cfg_r[1];

	////////////////////////////////////////////////////////////////////////
	// channels

	generate
		for (genvar i = 0; i < NCH; i++)
		begin : g_ch
			localparam logic [3:0] A_SC = 4'(ADR_CH_BASE + CH_STRIDE * i);
			localparam logic [3:0] A_HI = 4'(ADR_CH_BASE + CH_STRIDE * i + 1);
			localparam logic [3:0] A_LO = 4'(ADR_CH_BASE + CH_STRIDE * i + 2);

			assign ch_wr_sc[i] = reg_wr & (reg_addr == A_SC);
			assign ch_wr_hi[i] = reg_wr & (reg_addr == A_HI);
			assign ch_wr_lo[i] = reg_wr & (reg_addr == A_LO);

			// pin synchroniser
			always_ff @(posedge core_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					ch_s1_r[i] <= 1'b0;
					ch_s2_r[i] <= 1'b0;
				end
				else
				begin
					ch_s1_r[i] <= ch_pin[i];
					ch_s2_r[i] <= ch_s1_r[i];
				end
			end

			// channel configuration
			always_ff @(posedge core_clk or posedge sys_rst)
			begin
				if (sys_rst)
					ch_cfg_r[i] <= CH_CFG_RST;
				else if (ch_wr_sc[i])
				begin
					ch_cfg_r[i].irq_en <= reg_wdata[CH_IRQEN];
					ch_cfg_r[i].mode   <= reg_wdata[CH_MSB -: 2];
					ch_cfg_r[i].els    <= reg_wdata[CH_ELSB -: 2];
					ch_cfg_r[i].tov    <= reg_wdata[CH_TOV];
				end
			end

			// value registers: capture beats a software write
			always_ff @(posedge core_clk or posedge sys_rst)
			begin
				if (sys_rst)
					ch_val_r[i] <= CNT_ZERO;
				else if (cap_evt[i])
					ch_val_r[i] <= cnt_r;
				else if (ch_wr_hi[i])
					ch_val_r[i][15:8] <= reg_wdata;
				else if (ch_wr_lo[i])
					ch_val_r[i][7:0]  <= reg_wdata;
			end

			// event flag: set wins over a clear by writing zero
			always_ff @(posedge core_clk or posedge sys_rst)
			begin
				if (sys_rst)
					ch_flag_r[i] <= 1'b0;
				else if (cap_evt[i] || cmp_evt[i])
					ch_flag_r[i] <= 1'b1;
				else if (ch_wr_sc[i] && !reg_wdata[CH_FLAG])
					ch_flag_r[i] <= 1'b0;
			end

			dcpt_channel u_ch (
				.core_clk    (core_clk),
				.sys_rst     (sys_rst),
				.cfg         (ch_cfg_eff[i]),
				.pin_sync    (ch_s2_r[i]),
				.step        (step),
				.wrap        (wrap),
				.cnt_nxt     (cnt_nxt),
				.cmp_val     (ch_cmp[i]),
				.capture_evt (cap_evt[i]),
				.compare_evt (cmp_evt[i]),
				.pin_level_r (ch_drive[i])
			);
		end
	endgenerate

	assign ch_pin[0]              = channel_zero_pin_level;
	assign ch_pin[1]              = channel_one_pin_level;
	assign channel_zero_pin_drive = ch_drive[0];
	assign channel_one_pin_drive  = ch_drive[1];

	// pin drive enables; channel 1 pin released while linked
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			channel_zero_pin_oe <= 1'b0;
			channel_one_pin_oe  <= 1'b0;
		end
		else
		begin
			channel_zero_pin_oe <= (ch_cfg_eff[0].mode != MODE_CAPTURE) &&
				(ch_cfg_eff[0].els != ELS_OFF);
			channel_one_pin_oe  <= (ch_cfg_eff[1].mode != MODE_CAPTURE) &&
				(ch_cfg_eff[1].els != ELS_OFF);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt request and read port

	// enabled flags merge into one request line
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			irq_req <= 1'b0;
		else
			irq_req <= (ovf_flag_r & ovf_ie_r) |
				(ch_flag_r[0] & ch_cfg_r[0].irq_en) |
				(ch_flag_r[1] & ch_cfg_r[1].irq_en);
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_nxt = '0;
		unique case (reg_addr)
			ADR_STATUS:
				rd_nxt = {ovf_flag_r, ovf_ie_r, stop_r, 2'h0, ps_r};
			ADR_CNT_HI:
				rd_nxt = cnt_r[15:8];
			ADR_CNT_LO:
				rd_nxt = lo_hold_r ? lo_latch_r : cnt_r[7:0];
			ADR_MOD_HI:
				rd_nxt = mod_r[15:8];
			ADR_MOD_LO:
				rd_nxt = mod_r[7:0];
			4'(ADR_CH_BASE):
				rd_nxt = {ch_flag_r[0], ch_cfg_r[0], 1'b0};
			4'(ADR_CH_BASE + 1):
				rd_nxt = ch_val_r[0][15:8];
			4'(ADR_CH_BASE + 2):
				rd_nxt = ch_val_r[0][7:0];
			4'(ADR_CH_BASE + CH_STRIDE):
				rd_nxt = {ch_flag_r[1], ch_cfg_r[1], 1'b0};
			4'(ADR_CH_BASE + CH_STRIDE + 1):
				rd_nxt = ch_val_r[1][15:8];
			4'(ADR_CH_BASE + CH_STRIDE + 2):
				rd_nxt = ch_val_r[1][7:0];
			default:
				rd_nxt = '0;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rd_nxt;
		else
			reg_rdata <= '0;
	end

endmodule : dcpt_timer

// >>> common/dcpt_pkg.sv
// Purpose: constants, register map and carrier types of the two-channel timer
// Assumes: 8-bit register port, one core clock
// Notes: byte-wide registers at consecutive addresses
//
// Functional notes
// - 16-bit up-counter, free or modulo, time base
// - counter reads never disturb counting
// - wrap point from modulo high and low bytes
// - three-bit select: seven bus taps or pin
// - each channel independently capture or compare
// - active edge copies counter into channel value
// - capture event can request an interrupt
// - compare match sets, clears or toggles pin
// - unbuffered compare value replaced at once
// - buffered select links channels onto pin zero
// - linked: last written set takes over at overflow
// - linked: channel one unused, pin released
// - toggle-on-overflow toggles pin at wrap
// - pulse ends at compare, level by select bit
// - period counts modulo value plus one
// - pulse width equals channel value in ticks
// - stop halts counting, reset clears counter, prescaler
// - overflow flag set at wrap, gated interrupt
// - channel flag on each event, gated interrupt
// - mode encoding; buffered bit has priority
package dcpt_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;
	localparam int PRE_W  = 6;
	localparam int PS_W   = 3;
	localparam int NCH    = 2;

	// register addresses
	localparam logic [3:0] ADR_STATUS  = 4'h0;
	localparam logic [3:0] ADR_CNT_HI  = 4'h1;
	localparam logic [3:0] ADR_CNT_LO  = 4'h2;
	localparam logic [3:0] ADR_MOD_HI  = 4'h3;
	localparam logic [3:0] ADR_MOD_LO  = 4'h4;
	localparam int         ADR_CH_BASE = 5;
	localparam int         CH_STRIDE   = 3;

	// timer_status_control fields
	localparam int SC_FLAG  = 7;
	localparam int SC_IRQEN = 6;
	localparam int SC_STOP  = 5;
	localparam int SC_RST   = 4;
	// channel status/control fields
	localparam int CH_FLAG  = 7;
	localparam int CH_IRQEN = 6;
	localparam int CH_MSB   = 5;
	localparam int CH_ELSB  = 3;
	localparam int CH_TOV   = 1;

	localparam logic [PS_W-1:0]  PS_EXT   = 3'h7;
	localparam logic [PS_W-1:0]  PS_RST   = 3'h0;
	localparam logic [CNT_W-1:0] MOD_RST  = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic             STOP_RST = 1'b1;

	// mode_select_high:mode_select_low
	localparam logic [1:0] MODE_CAPTURE = 2'h0;
	// edge_level_select: capture edge or compare action
	localparam logic [1:0] ELS_OFF  = 2'h0;
	localparam logic [1:0] ELS_RISE = 2'h1;
	localparam logic [1:0] ELS_FALL = 2'h2;
	localparam logic [1:0] ELS_ANY  = 2'h3;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	typedef struct packed {
		logic       irq_en;
		logic [1:0] mode;
		logic [1:0] els;
		logic       tov;
	} dcpt_ch_cfg_t;

	localparam dcpt_ch_cfg_t CH_CFG_RST = '0;

endpackage : dcpt_pkg

// >>> design/dcpt_channel.sv
// Purpose: one capture/compare channel: edge detect, match, pin level
// Assumes: pin level already synchronised to core_clk
// Notes: value registers live in the top module
`timescale 1ns/100ps
module dcpt_channel
	import dcpt_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire dcpt_ch_cfg_t     cfg,
	input  wire logic             pin_sync,
	input  wire logic             step,
	input  wire logic             wrap,
	input  wire logic [CNT_W-1:0] cnt_nxt,
	input  wire logic [CNT_W-1:0] cmp_val,
	output logic                  capture_evt,
	output logic                  compare_evt,
	output logic                  pin_level_r
);

	logic pin_d_r;
	logic rise;
	logic fall;
	logic cmp_mode;
	logic pin_nxt;

	// previous pin level for edge detection
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			pin_d_r <= 1'b0;
		else
			pin_d_r <= pin_sync;
	end

	// capture on the selected edge; any nonzero mode is compare
	assign rise     = pin_sync & ~pin_d_r;
	assign fall     = ~pin_sync & pin_d_r;
	assign cmp_mode = (cfg.mode != MODE_CAPTURE);
	always_comb
	begin
		capture_evt = 1'b0;
		if (!cmp_mode)
		begin
			unique case (cfg.els)
				ELS_RISE: capture_evt = rise;
				ELS_FALL: capture_evt = fall;
				ELS_ANY:  capture_evt = rise | fall;
				default:  capture_evt = 1'b0;
			endcase
		end
	end

	// match when the counter steps onto the compare value
	assign compare_evt = cmp_mode & step & (cnt_nxt == cmp_val);

	// pin level: overflow toggle first, compare action last
	always_comb
	begin
		pin_nxt = pin_level_r;
		if (wrap && cfg.tov)
			pin_nxt = ~pin_nxt;
		if (compare_evt)
		begin
			unique case (cfg.els)
				ACT_TOGGLE: pin_nxt = ~pin_nxt;
				ACT_CLEAR:  pin_nxt = 1'b0;
				ACT_SET:    pin_nxt = 1'b1;
				default:    pin_nxt = pin_level_r;
			endcase
		end
	end

	// pin output register, frozen outside compare mode
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			pin_level_r <= 1'b0;
		else if (cmp_mode)
			pin_level_r <= pin_nxt;
	end

endmodule : dcpt_channel

// >>> bench/dcpt_checker.sv
// Purpose: port-level assertions for the two-channel timer
// Assumes: all control bits reach the block through register writes
// Notes: shadows a few control bytes from the write strobe
`timescale 1ns/100ps
module dcpt_checker
	import dcpt_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              channel_zero_pin_drive,
	input wire logic              channel_zero_pin_oe,
	input wire logic              channel_one_pin_oe,
	input wire logic              irq_req
);
	logic [7:0] sc0_r, sc0_p_r, sc1_r, sc1_p_r;
	logic       stop_r, en_p_r;
	logic [1:0] age_r;
	logic       en;
	////////////////////////////////////////////////////////////////////////////////
	// a channel interrupt enable set, or the status register addressed
	assign en = sc0_r[CH_IRQEN] | sc1_r[CH_IRQEN] | (reg_addr == ADR_STATUS);
	// shadow control bytes and a quiet-time count while stopped
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sc0_r   <= 8'h00;
			sc1_r   <= 8'h00;
			sc0_p_r <= 8'h00;
			sc1_p_r <= 8'h00;
			stop_r  <= STOP_RST;
			en_p_r  <= 1'b1;
			age_r   <= 2'h0;
		end
		else
		begin
			sc0_p_r <= sc0_r;
			sc1_p_r <= sc1_r;
			en_p_r  <= en | irq_req;
			age_r   <= (reg_wr || !stop_r) ? 2'h0 : ((age_r == 2'h3) ? age_r : age_r + 2'h1);
			if (reg_wr && reg_addr == ADR_STATUS)
				stop_r <= reg_wdata[SC_STOP];
			if (reg_wr && reg_addr == 4'h5)
				sc0_r <= reg_wdata;
			if (reg_wr && reg_addr == 4'h8)
				sc1_r <= reg_wdata;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_rdata_unmapped: assert property ($past(reg_rd) && $past(reg_addr) > 4'ha |->
		reg_rdata == 8'h00) else $error("unmapped address read nonzero");
	a_oe0_config: assert property (sc0_r == sc0_p_r |-> channel_zero_pin_oe ==
		(|sc0_r[5:4] && |sc0_r[3:2])) else $error("channel zero enable wrong");
	a_oe1_config: assert property (sc1_r == sc1_p_r && !sc1_r[5] && !sc0_r[5] && !sc0_p_r[5]
		|-> channel_one_pin_oe == (sc1_r[4] && |sc1_r[3:2]))
		else $error("channel one enable wrong");
	a_linked_free: assert property (sc0_r[CH_MSB] && sc0_p_r[CH_MSB] |-> !channel_one_pin_oe)
		else $error("channel one pin driven while linked");
	a_irq_gated: assert property (!en_p_r && !sc0_r[CH_IRQEN] |=> !irq_req)
		else $error("interrupt without enable");
	a_stop_holds: assert property (age_r == 2'h3 |-> $stable(channel_zero_pin_drive))
		else $error("pin moved while stopped");
	a_rst_release: assert property ($fell(sys_rst) |-> !irq_req && !channel_zero_pin_oe
		&& !channel_one_pin_oe) else $error("outputs active after reset");
	c_pwm_edge: cover property (channel_zero_pin_oe && $rose(channel_zero_pin_drive));
	c_irq: cover property ($rose(irq_req));
	c_linked: cover property (sc0_r[CH_MSB] && age_r == 2'h0);
endmodule : dcpt_checker

// >>> bench/dcpt_pin_model.sv
// Purpose: event sources and loads on the channel and clock pins
// Assumes: pins have no pull; a released pin shows the source level
// Notes: the external clock stands still unless the bench pulses it
`timescale 1ns/100ps
module dcpt_pin_model
(
	input  wire logic drive0,
	input  wire logic oe0,
	input  wire logic drive1,
	input  wire logic oe1,
	input  wire logic stim0,
	input  wire logic stim1,
	input  wire logic ext_stim,
	output logic      level0,
	output logic      level1,
	output logic      ext_clk
);
	// a driven pin shows the device level, a released one the source
	assign level0  = oe0 ? drive0 : stim0;
	assign level1  = oe1 ? drive1 : stim1;
	assign ext_clk = ext_stim;
endmodule : dcpt_pin_model

// >>> bench/dcpt_timer_tb.sv
// Purpose: self-checking bench for the two-channel timer
// Assumes: 10 MHz core clock, byte register port
// Notes: pulse widths are counted in core cycles at prescaler 0
`timescale 1ns/100ps
module dcpt_timer_tb
	import dcpt_pkg::*;
;
	logic              core_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 8'h00;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              external_timer_clock_pin, channel_zero_pin_level, channel_one_pin_level;
	logic              channel_zero_pin_drive, channel_zero_pin_oe, irq_req;
	logic              channel_one_pin_drive, channel_one_pin_oe;
	logic              ext_stim = 1'b0;
	logic              stim1 = 1'b0;
	logic [7:0]        c, d, h, l;
	int                failures = 0;
	int                n_compared = 0;
	int                k;
	always #50 core_clk = ~core_clk;
	dcpt_timer i_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.external_timer_clock_pin, .channel_zero_pin_level, .channel_zero_pin_drive,
		.channel_zero_pin_oe, .channel_one_pin_level, .channel_one_pin_drive,
		.channel_one_pin_oe, .irq_req);
	dcpt_pin_model i_pins (.drive0(channel_zero_pin_drive), .oe0(channel_zero_pin_oe),
		.drive1(channel_one_pin_drive), .oe1(channel_one_pin_oe), .stim0(1'b0), .stim1(stim1),
		.ext_stim(ext_stim), .level0(channel_zero_pin_level), .level1(channel_one_pin_level),
		.ext_clk(external_timer_clock_pin));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// cycles that channel zero stays at one level, bounded
	task automatic span(input logic lvl, output int n);
		n = 0;
		while (channel_zero_pin_drive === lvl)
		begin
			@(posedge core_clk);
			#1 n++;
			if (n > 1000)
			begin
				failures++;
				close_out();
			end
		end
	endtask : span
	// skip to a settled period, then time pulse and rest
	task automatic meas(input logic pl, input logic [7:0] w);
		span(!pl, k);
		span(pl, k);
		span(!pl, k);
		span(pl, k);
		chk("pulse width", 16'(k), {8'h00, w});
		span(!pl, k);
		chk("period rest", 16'(k), 16'h0100 - {8'h00, w});
	endtask : meas
	task automatic pwm(input logic [7:0] sc, input logic pl, input logic [7:0] w);
		wr(4'h5, sc);
		wr(4'h7, w);
		wr(ADR_STATUS, 8'h10);
		meas(pl, w);
	endtask : pwm
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(ADR_STATUS, d);
		chk("status reset", d, 8'h20);
		rd(ADR_MOD_HI, d);
		chk("modulo high", d, 8'hff);
		rd(4'hc, d);
		chk("unmapped", d, 8'h00);
		wr(ADR_CNT_HI, 8'h55);
		rd(ADR_CNT_HI, d);
		chk("counter read only", d, 8'h00);
		wr(ADR_MOD_HI, 8'h00);
		pwm(8'h1a, 1'b1, 8'h40);
		pwm(8'h1e, 1'b0, 8'h40);
		pwm(8'h1a, 1'b1, 8'h80);
		rd(ADR_STATUS, d);
		chk("overflow flag", d, 8'h80);
		wr(ADR_STATUS, 8'h40);
		repeat (300) @(posedge core_clk);
		#1 chk("overflow irq", irq_req, 1'b1);
		wr(ADR_STATUS, 8'h20);
		repeat (3) @(posedge core_clk);
		#1 chk("irq cleared", irq_req, 1'b0);
		rd(ADR_CNT_HI, h);
		rd(ADR_CNT_LO, l);
		repeat (20) @(posedge core_clk);
		rd(ADR_CNT_HI, c);
		rd(ADR_CNT_LO, d);
		chk("stopped count", {c, d}, {h, l});
		for (int e = 1; e < 4; e++)
		begin
			wr(4'h8, 8'h40 | 8'(e << 2));
			stim1 <= 1'b1;
			repeat (6) @(posedge core_clk);
			#1 chk("capture irq", irq_req, e != 2);
			rd(4'h8, d);
			chk("rise flag", d[7], e != 2);
			wr(4'h8, 8'h40 | 8'(e << 2));
			stim1 <= 1'b0;
			repeat (6) @(posedge core_clk);
			rd(4'h8, d);
			chk("fall flag", d[7], e != 1);
		end
		rd(4'h9, c);
		rd(4'ha, d);
		chk("captured value", {c, d}, {h, l});
		wr(ADR_STATUS, 8'h30);
		rd(ADR_CNT_HI, c);
		rd(ADR_CNT_LO, d);
		chk("counter cleared", {c, d}, 16'h0000);
		wr(ADR_STATUS, 8'h17);
		repeat (5)
		begin
			ext_stim <= 1'b1;
			repeat (4) @(posedge core_clk);
			ext_stim <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		wr(ADR_STATUS, 8'h27);
		rd(ADR_CNT_HI, c);
		rd(ADR_CNT_LO, d);
		chk("external clock count", {c, d}, 16'h0005);
		// channel one as a plain compare: set, then clear on match
		wr(4'h8, 8'h1c);
		wr(4'ha, 8'h08);
		wr(ADR_STATUS, 8'h00);
		repeat (8) @(posedge core_clk);
		#1 chk("channel one set", channel_one_pin_drive, 1'b1);
		wr(4'h8, 8'h18);
		repeat (300) @(posedge core_clk);
		#1 chk("channel one clear", channel_one_pin_drive, 1'b0);
		// old flag cleared, rising capture armed before linking
		wr(4'h8, 8'h04);
		pwm(8'h2a, 1'b1, 8'h40);
		wr(4'ha, 8'h20);
		stim1 <= 1'b1;
		meas(1'b1, 8'h20);
		rd(4'h8, d);
		chk("linked channel one flag", d[7], 1'b0);
		chk("channel one released", channel_one_pin_level, 1'b1);
		close_out();
	end
endmodule : dcpt_timer_tb
bind dcpt_timer dcpt_checker i_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .channel_zero_pin_drive, .channel_zero_pin_oe, .channel_one_pin_oe,
	.irq_req);
